// [hw/bpc_bus_ctrl.sv]
// External bus pin controller: strobes, arbitration handshake, data and parity,
// general port pins, interrupt gating and clock output.
// Assumes one 200 MHz clock, synchronous pin inputs and an external arbiter.
`timescale 1ns/10ps
module bpc_bus_ctrl (
    input  wire logic                           clock,
    input  wire logic                           rstn,
    input  wire logic                           memory_area_zero_is_sram,
    input  wire logic                           req_valid,
    input  wire bpc_pkg::bpc_req_type           req,
    output logic                                req_ready,
    output logic                                done,
    output logic      [bpc_pkg::DATA_W-1:0]     read_data,
    output logic                                parity_error,
    input  wire logic                           grant_n,
    output logic                                bus_request,
    output logic                                bus_master_active,
    output logic                                bus_drive_en,
    output logic      [bpc_pkg::ADDR_W-1:0]     address,
    output bpc_pkg::bpc_strobe_type             strobes,
    input  wire logic [bpc_pkg::DATA_W-1:0]     data_in,
    output logic      [bpc_pkg::DATA_W-1:0]     data_out,
    output logic                                data_oe,
    input  wire logic [bpc_pkg::LANES-1:0]      parity_in,
    output logic      [bpc_pkg::LANES-1:0]      parity_out,
    output logic                                parity_oe,
    input  wire bpc_pkg::bpc_fcr_type           function_control_register,
    input  wire logic                           interrupt_lock,
    input  wire logic [bpc_pkg::INTS-1:0]       interrupt_inputs,
    output logic      [bpc_pkg::INTS-1:0]       interrupt_take,
    input  wire logic [bpc_pkg::PORT_PINS-1:0]  port_pin_in,
    output logic      [bpc_pkg::PORT_PINS-1:0]  port_pin_out,
    output logic      [bpc_pkg::PORT_PINS-1:0]  port_pin_oe,
    output logic      [bpc_pkg::PORT_PINS-1:0]  port_pin_value,
    output logic                                peripheral_clock_out
);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ASK,
        ST_SETUP,
        ST_STROBE,
        ST_END
    } bpc_state_type;

    bpc_state_type           state_reg;
    bpc_state_type           state_next;
    bpc_pkg::bpc_req_type    cur_reg;
    bpc_pkg::bpc_strobe_type strobes_next;
    logic [1:0]              strobe_count_reg;
    logic                    take;
    logic                    strobe_done;
    logic                    on_bus_next;
    logic                    drives_data_next;

    assign take        = req_valid && req_ready;
    assign strobe_done = (state_reg == ST_STROBE) && (strobe_count_reg == bpc_pkg::STROBE_LAST);

    // Sequencer: request, wait for grant, setup, strobe, release
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:   if (take) state_next = ST_ASK;
            ST_ASK:    if (!grant_n) state_next = ST_SETUP;
            ST_SETUP:  state_next = ST_STROBE;
            ST_STROBE: if (strobe_done) state_next = ST_END;
            ST_END:    state_next = ST_IDLE;
            default:   state_next = ST_IDLE;
        endcase
    end

    // State and access capture; reset forces idle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state_reg <= ST_IDLE;
            cur_reg   <= '0;
        end
        else
        begin
            state_reg <= state_next;
            if (take)
                cur_reg <= req;
        end
    end

    // Strobe phase counter
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            strobe_count_reg <= 2'h0;
        else if (state_reg == ST_STROBE && !strobe_done)
            strobe_count_reg <= strobe_count_reg + 2'h1;
        else
            strobe_count_reg <= 2'h0;
    end

    // Strobe decode from the coming state, so registered pins line up with it
    always_comb
    begin
        strobes_next = bpc_pkg::STROBES_IDLE;
        if (state_next == ST_SETUP || state_next == ST_STROBE)
        begin
            if (cur_reg.kind != bpc_pkg::BPC_KIND_REFRESH)
                strobes_next.write_n = !cur_reg.write;
            case (cur_reg.kind)
                bpc_pkg::BPC_KIND_DRAM:
                begin
                    strobes_next.row_n = 1'b0;
                    if (state_next == ST_STROBE)
                        strobes_next.column_strobe_n = ~cur_reg.bytes;
                end
                bpc_pkg::BPC_KIND_REFRESH:
                begin
                    // Column strobes lead, row follows: CAS-before-RAS refresh
                    strobes_next.column_strobe_n = '0;
                    if (state_next == ST_STROBE)
                        strobes_next.row_n = 1'b0;
                end
                bpc_pkg::BPC_KIND_MEM:
                begin
                    if (cur_reg.area == 2'h0)
                        strobes_next.row_n = !memory_area_zero_is_sram;
                    else
                        strobes_next.area_select_n[cur_reg.area - 2'h1] = 1'b0;
                    if (state_next == ST_STROBE && !cur_reg.write)
                        strobes_next.output_enable_n = 1'b0;
                    if (state_next == ST_STROBE && cur_reg.write)
                        strobes_next.byte_write_n = ~cur_reg.bytes;
                end
                bpc_pkg::BPC_KIND_IO:
                begin
                    if (state_next == ST_STROBE)
                    begin
                        // Data strobe mode uses the read pin for both directions
                        if (cur_reg.addr[bpc_pkg::IO_MODE_BIT])
                            strobes_next.io_read_strobe_n = 1'b0;
                        else if (cur_reg.write)
                            strobes_next.io_write_strobe_n = 1'b0;
                        else
                            strobes_next.io_read_strobe_n = 1'b0;
                    end
                end
                default: strobes_next = bpc_pkg::STROBES_IDLE;
            endcase
        end
    end

    assign on_bus_next      = (state_next == ST_SETUP) || (state_next == ST_STROBE) ||
                              (state_next == ST_END);
    assign drives_data_next = cur_reg.write && (cur_reg.kind != bpc_pkg::BPC_KIND_REFRESH) &&
                              ((state_next == ST_SETUP) || (state_next == ST_STROBE));

    // Registered strobe pins; idle level outside an access
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            strobes <= bpc_pkg::STROBES_IDLE;
        else
            strobes <= strobes_next;
    end

    // Arbitration handshake and tristate control of address and strobes
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            req_ready         <= 1'b0;
            bus_request       <= 1'b0;
            bus_master_active <= 1'b0;
            bus_drive_en      <= 1'b0;
            address           <= '0;
        end
        else
        begin
            req_ready         <= (state_next == ST_IDLE);
            bus_request       <= (state_next == ST_ASK) || on_bus_next;
            bus_master_active <= on_bus_next;
            bus_drive_en      <= on_bus_next;
            address           <= on_bus_next ? cur_reg.addr : '0;
        end
    end

    // Write data and parity drive; the pins float outside the write phases
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            data_out   <= '0;
            data_oe    <= 1'b0;
            parity_out <= '0;
            parity_oe  <= 1'b0;
        end
        else
        begin
            data_oe    <= drives_data_next;
            parity_oe  <= drives_data_next;
            data_out   <= drives_data_next ? cur_reg.wdata : '0;
            parity_out <= drives_data_next ? bpc_pkg::byte_parity(cur_reg.wdata) : '0;
        end
    end

    // Read capture and parity check at the last strobe cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            done         <= 1'b0;
            read_data    <= '0;
            parity_error <= 1'b0;
        end
        else
        begin
            done         <= strobe_done;
            parity_error <= 1'b0;
            if (strobe_done && !cur_reg.write && cur_reg.kind != bpc_pkg::BPC_KIND_REFRESH)
            begin
                read_data    <= data_in;
                // Only lanes that were read can raise an error
                parity_error <= |((bpc_pkg::byte_parity(data_in) ^ parity_in)
                                  & cur_reg.bytes);
            end
        end
    end

    // General port pins: direction and drive come from the control register
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            port_pin_oe    <= '0;
            port_pin_out   <= '0;
            port_pin_value <= '0;
        end
        else
        begin
            port_pin_oe    <= function_control_register.port_pin_direction;
            port_pin_out   <= function_control_register.port_pin_drive;
            port_pin_value <= port_pin_in;
        end
    end

    bpc_irq_gate u_irq_gate (
        .clock                (clock),
        .rstn                 (rstn),
        .interrupt_inputs     (interrupt_inputs),
        .interrupt_input_mask (function_control_register.interrupt_input_mask),
        .interrupt_lock       (interrupt_lock),
        .interrupt_take       (interrupt_take)
    );

    bpc_clock_out u_clock_out (
        .clock                (clock),
        .rstn                 (rstn),
        .peripheral_clock_out (peripheral_clock_out)
    );

    // Checks on the pin behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    sequence seq_granted;
        (state_reg == ST_ASK) && !grant_n;
    endsequence

    sequence seq_tenure;
        bus_master_active [*4] ##1 !bus_master_active;
    endsequence

    chk_grant_act: assert property (seq_granted |=> seq_tenure)
        else $error("bus master active tenure wrong after grant");

    chk_request_up: assert property (take |=> bus_request && !bus_master_active)
        else $error("bus request not raised for taken access");

    chk_float_idle: assert property (!bus_master_active |-> !bus_drive_en && !data_oe)
        else $error("bus pins driven without the bus");

    chk_cas_dram: assert property ((strobes.column_strobe_n != '1) |->
        (cur_reg.kind == bpc_pkg::BPC_KIND_DRAM || cur_reg.kind == bpc_pkg::BPC_KIND_REFRESH))
        else $error("column strobe outside a DRAM cycle");

    chk_ras_use: assert property ($fell(strobes.row_n) |->
        cur_reg.kind == bpc_pkg::BPC_KIND_DRAM || cur_reg.kind == bpc_pkg::BPC_KIND_REFRESH ||
        (cur_reg.kind == bpc_pkg::BPC_KIND_MEM && cur_reg.area == 2'h0 && memory_area_zero_is_sram))
        else $error("row strobe for the wrong cycle");

    chk_refresh_order: assert property (
        (state_reg == ST_SETUP && cur_reg.kind == bpc_pkg::BPC_KIND_REFRESH) |->
        (strobes.column_strobe_n == '0 && strobes.row_n) ##1 !strobes.row_n)
        else $error("refresh strobes out of order");

    chk_write_level: assert property ((state_reg == ST_STROBE &&
        cur_reg.kind != bpc_pkg::BPC_KIND_REFRESH) |-> strobes.write_n == !cur_reg.write)
        else $error("write enable level wrong");

    chk_area_one: assert property ((strobes.area_select_n != '1) |->
        $onehot(~strobes.area_select_n) && !strobes.area_select_n[cur_reg.area - 2'h1])
        else $error("area select wrong");

    chk_byte_lanes: assert property ((strobes.byte_write_n != '1) |->
        cur_reg.write && (~strobes.byte_write_n == cur_reg.bytes))
        else $error("byte write enable on an unwritten lane");

    chk_oe_read: assert property (!strobes.output_enable_n |->
        !cur_reg.write && cur_reg.kind == bpc_pkg::BPC_KIND_MEM)
        else $error("output enable outside a memory read");

    chk_io_mode: assert property ((state_reg == ST_STROBE &&
        cur_reg.kind == bpc_pkg::BPC_KIND_IO && cur_reg.addr[bpc_pkg::IO_MODE_BIT]) |->
        !strobes.io_read_strobe_n && strobes.io_write_strobe_n)
        else $error("data strobe mode not honoured");

    chk_parity_drive: assert property (data_oe |-> parity_oe &&
        parity_out == bpc_pkg::byte_parity(data_out))
        else $error("parity lines disagree with write data");

    chk_port_dir: assert property (1'b1 |=> port_pin_oe == $past(function_control_register.port_pin_direction))
        else $error("port direction not followed");

endmodule // bpc_bus_ctrl

// [hw/bpc_clock_out.sv]
// Divider that makes the peripheral clock output from the processor clock.
// Assumes the processor clock is the only clock; the output is a registered level.
`timescale 1ns/10ps
module bpc_clock_out (
    input  wire logic clock,
    input  wire logic rstn,
    output logic      peripheral_clock_out
);

    logic [3:0] div_count_reg;
    logic       half_tick_reg;

    // Half-period enable pulse; one cycle wide
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            div_count_reg <= 4'h0;
            half_tick_reg <= 1'b0;
        end
        else if (div_count_reg == bpc_pkg::PERIPHERAL_CLOCK_OUT_LAST)
        begin
            div_count_reg <= 4'h0;
            half_tick_reg <= 1'b1;
        end
        else
        begin
            div_count_reg <= div_count_reg + 4'h1;
            half_tick_reg <= 1'b0;
        end
    end

    // Toggle on each enable so peripherals see a clean square wave
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            peripheral_clock_out <= 1'b0;
        else if (half_tick_reg)
            peripheral_clock_out <= !peripheral_clock_out;
    end

    chk_peripheral_clock_out_toggle: assert property (@(posedge clock) disable iff (!rstn)
        half_tick_reg |=> (peripheral_clock_out != $past(peripheral_clock_out)))
        else $error("clock output missed its toggle");

endmodule // bpc_clock_out

// [hw/bpc_irq_gate.sv]
// Gating of the four interrupt inputs by lock flag and per-input mask.
// Assumes inputs are already synchronous; a taken bit stays while its cause stays.
`timescale 1ns/10ps
module bpc_irq_gate (
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire logic [bpc_pkg::INTS-1:0]  interrupt_inputs,
    input  wire logic [bpc_pkg::INTS-1:0]  interrupt_input_mask,
    input  wire logic                      interrupt_lock,
    output logic      [bpc_pkg::INTS-1:0]  interrupt_take
);

    // A request is passed only while unlocked and unmasked
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            interrupt_take <= '0;
        else if (interrupt_lock)
            interrupt_take <= '0;
        else
            interrupt_take <= interrupt_inputs & ~interrupt_input_mask;
    end

    chk_irq_masked: assert property (@(posedge clock) disable iff (!rstn)
        (interrupt_take != '0) |->
            !$past(interrupt_lock) &&
            ((interrupt_take & $past(interrupt_input_mask)) == '0))
        else $error("interrupt taken while locked or masked");

endmodule // bpc_irq_gate

// [hw/bpc_pkg.sv]
// Shared types, field layouts and constants of the external bus pin controller.
// Assumes a single 200 MHz clock; every user of this package writes bpc_pkg::name.
package bpc_pkg;

    // Widths of the external buses and pin groups
    localparam int ADDR_W    = 26;
    localparam int DATA_W    = 32;
    localparam int LANES     = 4;
    localparam int AREAS     = 3;
    localparam int INTS      = 4;
    localparam int PORT_PINS = 3;

    // Address bit that turns the I/O read pin into a combined data strobe
    localparam int IO_MODE_BIT = 10;

    // Access timing in clock cycles
    localparam logic [1:0] STROBE_CYCLES = 2'h2;
    localparam logic [1:0] STROBE_LAST   = STROBE_CYCLES - 2'h1;

    // Clock output: half period in processor clocks
    localparam logic [3:0] PERIPHERAL_CLOCK_OUT_HALF = 4'h2;
    localparam logic [3:0] PERIPHERAL_CLOCK_OUT_LAST = PERIPHERAL_CLOCK_OUT_HALF - 4'h1;

    // Kind of external cycle asked for by the core
    typedef enum logic [1:0] {
        BPC_KIND_DRAM,
        BPC_KIND_REFRESH,
        BPC_KIND_MEM,
        BPC_KIND_IO
    } bpc_kind_type;

    // One access request from the core side
    typedef struct packed {
        bpc_kind_type        kind;
        logic                write;
        logic [1:0]          area;
        logic [LANES-1:0]    bytes;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } bpc_req_type;

    // All active-low bus control strobes, driven together
    typedef struct packed {
        logic                row_n;
        logic [LANES-1:0]    column_strobe_n;
        logic                write_n;
        logic [AREAS-1:0]    area_select_n;
        logic [LANES-1:0]    byte_write_n;
        logic                output_enable_n;
        logic                io_read_strobe_n;
        logic                io_write_strobe_n;
    } bpc_strobe_type;

    localparam bpc_strobe_type STROBES_IDLE = 16'hFFFF;

    // Function control register fields used by this block
    typedef struct packed {
        logic [INTS-1:0]      interrupt_input_mask;
        logic [PORT_PINS-1:0] port_pin_direction;
        logic [PORT_PINS-1:0] port_pin_drive;
    } bpc_fcr_type;

    // Even parity of each data byte lane
    function automatic logic [LANES-1:0] byte_parity(input logic [DATA_W-1:0] d);
        logic [LANES-1:0] p;
        p = '0;
        for (int i = 0; i < LANES; i++)
        begin
            p[i] = ^d[i*8 +: 8];
        end
        return p;
    endfunction

endpackage

// [test/bpc_bus_ctrl_bench.sv]
// Bench for the bus pin controller; queued notes are retired at each done pulse.
// Assumes bpc_far_model stands on the pin side.
`timescale 1ns/10ps
module bpc_bus_ctrl_bench;
    typedef struct packed {
        bpc_pkg::bpc_req_type r;
        logic                 sram;
        logic                 bad;
        logic [31:0]          mem;
    } bpc_note_type;
    logic clock = 1'b0, rstn = 1'b0, memory_area_zero_is_sram = 1'b0, req_valid = 1'b0, bad = 1'b0;
    logic interrupt_lock = 1'b0, req_ready, done, parity_error, grant_n, bus_request;
    logic bus_master_active, bus_drive_en, data_oe, parity_oe, peripheral_clock_out, pclk;
    logic [31:0] read_data, data_in, data_out, mem_word = 32'h0;
    logic [25:0] address, pa;
    logic [37:0] pd;
    logic [3:0] parity_in, parity_out, interrupt_inputs = 4'h0, interrupt_take, pit;
    logic [2:0] port_pin_in = 3'h0, port_pin_out, port_pin_oe, port_pin_value, pdir, ppin, pdrv;
    logic [2:0] delay = 3'h0;
    logic pv = 1'b0, rdok;
    logic [127:0] sv, ev;
    bpc_pkg::bpc_req_type req = '0;
    bpc_pkg::bpc_strobe_type strobes, ps;
    bpc_pkg::bpc_fcr_type function_control_register = '0;
    bpc_note_type q[$], nt;
    int n_fail = 0, samples_checked = 0, run = 0;

    bpc_bus_ctrl i_dut (.clock, .rstn, .memory_area_zero_is_sram, .req_valid, .req, .req_ready, .done,
        .read_data, .parity_error, .grant_n, .bus_request, .bus_master_active, .bus_drive_en,
        .address, .strobes, .data_in, .data_out, .data_oe, .parity_in, .parity_out, .parity_oe,
        .function_control_register, .interrupt_lock, .interrupt_inputs, .interrupt_take, .port_pin_in, .port_pin_out,
        .port_pin_oe, .port_pin_value, .peripheral_clock_out);
    bpc_far_model i_far (.clock, .rstn, .bus_request, .bus_master_active, .data_oe, .delay,
        .mem_word, .bad, .grant_n, .data_in, .parity_in);

    // 200 MHz clock
    initial
    begin
        forever #2.5 clock = ~clock;
    end

    function automatic logic [3:0] par(input logic [31:0] d);
        return {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]};
    endfunction

    // Strobe pattern expected in the last strobe cycle of an access
    function automatic bpc_pkg::bpc_strobe_type exp_s(input bpc_note_type n);
        logic d, f, m, io, w;
        bpc_pkg::bpc_strobe_type s;
        d = n.r.kind == bpc_pkg::BPC_KIND_DRAM;
        f = n.r.kind == bpc_pkg::BPC_KIND_REFRESH;
        m = n.r.kind == bpc_pkg::BPC_KIND_MEM;
        io = n.r.kind == bpc_pkg::BPC_KIND_IO;
        w = n.r.write;
        s.row_n = !(d || f || (m && n.r.area == 2'h0 && n.sram));
        s.column_strobe_n = d ? ~n.r.bytes : (f ? 4'h0 : 4'hF);
        s.write_n = !w;
        s.area_select_n = ~((m && n.r.area != 2'h0) ? 3'h1 << (n.r.area - 2'h1) : 3'h0);
        s.byte_write_n = (m && w) ? ~n.r.bytes : 4'hF;
        s.output_enable_n = !(m && !w);
        s.io_read_strobe_n = !(io && (!w || n.r.addr[bpc_pkg::IO_MODE_BIT]));
        s.io_write_strobe_n = !(io && w && !n.r.addr[bpc_pkg::IO_MODE_BIT]);
        return s;
    endfunction

    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bounded wait for idle; a hang ends the run
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40 && !(i > 0 && req_ready === 1'b1); i++)
            @(posedge clock);
        check(req_ready, 1'b1);
        if (req_ready !== 1'b1)
            finish_test();
    endtask

    // One access; inputs change only at idle so the previous access is never disturbed
    task automatic do_req(input int k, input int w, input int a, input int s, input logic b);
        bpc_note_type n;
        wait_idle();
        n.r = '{bpc_pkg::bpc_kind_type'(k), 1'(w) & (k != 1), 2'(a), 4'($urandom) | 4'h1,
                26'($urandom), $urandom};
        n.r.addr[bpc_pkg::IO_MODE_BIT] = 1'(w ^ a);
        n.sram = 1'(s);
        n.bad = b;
        n.mem = $urandom;
        q.push_back(n);
        req <= n.r;
        req_valid <= 1'b1;
        memory_area_zero_is_sram <= n.sram;
        bad <= b;
        mem_word <= n.mem;
        delay <= 3'($urandom);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask

    // Monitor and side-pin stimulus; side pins wander to meet every mask and lock mix
    always @(posedge clock)
    begin
        if (pv && rstn)
        begin
            check(interrupt_take, pit);
            check({port_pin_oe, port_pin_out, port_pin_value}, {pdir, pdrv, ppin});
            check({bus_drive_en, bus_drive_en ? 26'h0 : address}, {bus_master_active, 26'h0});
        end
        if (done === 1'b1)
        begin
            check(q.size() != 0, 1'b1);
            nt = q.pop_front();
            rdok = !nt.r.write && nt.r.kind != bpc_pkg::BPC_KIND_REFRESH;
            sv = {ps, pa, pd[37:36], nt.r.write ? pd[35:0] : 36'h0, rdok ? read_data : 32'h0,
                  parity_error, bus_request, bus_master_active};
            ev = {exp_s(nt), nt.r.addr, {2{nt.r.write}},
                  nt.r.write ? {nt.r.wdata, par(nt.r.wdata)} : 36'h0,
                  rdok ? nt.mem : 32'h0, rdok & nt.bad, 2'h3};
            check(sv, ev);
        end
        if (!rstn)
            run = 0;
        else if (peripheral_clock_out !== pclk)
        begin
            if (run != 0)
                check(run, bpc_pkg::PERIPHERAL_CLOCK_OUT_HALF);
            run = 1;
        end
        else if (run != 0)
            run++;
        ps = strobes;
        pa = address;
        pd = {data_oe, parity_oe, data_out, parity_out};
        pit = interrupt_inputs & ~function_control_register.interrupt_input_mask & {4{!interrupt_lock}};
        pdir = function_control_register.port_pin_direction;
        pdrv = function_control_register.port_pin_drive;
        ppin = port_pin_in;
        pclk = peripheral_clock_out;
        pv = rstn;
        function_control_register <= bpc_pkg::bpc_fcr_type'(10'($urandom));
        interrupt_lock <= 1'($urandom);
        interrupt_inputs <= 4'($urandom);
        port_pin_in <= 3'($urandom);
    end

    // Sweep of kinds, directions, areas and memory type, then parity faults and reset
    initial
    begin
        void'($urandom(32'hEE1B3B17));
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++)
            for (int m = 0; m < 16; m++)
                do_req(k, m & 1, (m >> 1) & 3, m >> 3, 1'b0);
        $display("test sweep done");
        do_req(2, 0, 1, 0, 1'b1);
        do_req(0, 0, 0, 0, 1'b1);
        $display("test parity done");
        do_req(0, 1, 0, 0, 1'b0);
        repeat (3) @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        check({strobes, bus_request, bus_master_active, req_ready}, {16'hFFFF, 3'h0});
        q.delete();
        rstn <= 1'b1;
        do_req(3, 1, 0, 0, 1'b0);
        wait_idle();
        check(q.size(), 0);
        $display("test reset done");
        finish_test();
    end
endmodule // bpc_bus_ctrl_bench

// [test/bpc_far_model.sv]
// Far side of the pins: a bus arbiter plus a memory that answers reads.
// Assumes the bench sets grant delay, data word and parity fault per access.
`timescale 1ns/10ps
module bpc_far_model (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        bus_request,
    input  wire logic        bus_master_active,
    input  wire logic        data_oe,
    input  wire logic [2:0]  delay,
    input  wire logic [31:0] mem_word,
    input  wire logic        bad,
    output logic             grant_n,
    output logic      [31:0] data_in,
    output logic      [3:0]  parity_in
);
    logic [2:0] wait_reg;

    // Grant after a chosen wait, so a slow arbiter holds the device asking
    always @(posedge clock or negedge rstn)
    begin
        if (!rstn || !bus_request)
        begin
            wait_reg <= 3'h0;
            grant_n  <= 1'b1;
        end
        else if (wait_reg >= delay)
            grant_n <= 1'b0;
        else
            wait_reg <= wait_reg + 3'h1;
    end

    // Memory drives while the device holds the bus and drives no data; otherwise the lines keep changing
    // Cleared in reset so the lines are known before the first access
    always @(posedge clock)
        data_in <= !rstn ? 32'h0 : ((bus_master_active && !data_oe) ? mem_word : ~data_in);

    // Even parity per lane, lane zero spoiled on request
    assign parity_in = {^data_in[31:24], ^data_in[23:16], ^data_in[15:8], ^data_in[7:0]}
                     ^ {3'h0, bad};
endmodule // bpc_far_model
